// file: logic/ssp_regs.svh
// register offsets, field positions, reset values and counts of the serial port
//----------------------------------------------------------------
//----------------------------------------------------------------
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH

//----------------------------------------------------------------
// register offsets
//----------------------------------------------------------------
`define SSP_OFS_TXDATA 4'h2
`define SSP_OFS_CTRL 4'h4
`define SSP_OFS_STATUS 4'h6
`define SSP_OFS_FIFOCTL 4'h8
`define SSP_OFS_COUNT 4'ha

//----------------------------------------------------------------
// fields and reset values
//----------------------------------------------------------------
`define SSP_CTRL_RESET 16'h0000
`define SSP_CTRL_WMASK 16'h077f
`define SSP_ST_BELOW_WM 1
`define SSP_ST_UNDERRUN 3
`define SSP_ST_CTL_RX 8
`define SSP_ST_CTL_TX 9
`define SSP_FC_WM_HI 15
`define SSP_FC_WM_LO 12
`define SSP_FC_LSB 2
`define SSP_FC_FLUSH 0
`define SSP_CNT_HI 12
`define SSP_CNT_LO 8
`define SSP_FIFO_FULL 5'h10
`define SSP_BITS16 4'hf
`define SSP_BITS8 4'h7

`endif

// file: logic/ssp_pkg.sv
// types shared by the serial port transmit fifo and control logic
package ssp_pkg;

    // control register layout, bit fifteen down to bit zero
    typedef struct packed {
        logic [4:0] rsv_hi;
        logic dma_route_en;
        logic ctl_tx_irq_en;
        logic ctl_rx_irq_en;
        logic rsv7;
        logic sync_source_sel;
        logic framing_mode_bit;
        logic word_length_bit;
        logic tx_irq_en;
        logic rx_irq_en;
        logic tx_enable_bit;
        logic rx_enable_bit;
    } ssp_ctrl_t;

    // one register access from cpu or dma
    typedef struct packed {
        logic wr;
        logic rd;
        logic dma;
        logic [3:0] addr;
        logic [15:0] wdata;
    } ssp_req_t;

    // transmit engine states
    typedef enum logic [0:0] {
        SSP_IDLE = 1'b0,
        SSP_SHIFT = 1'b1
    } ssp_state_t;

endpackage : ssp_pkg

// file: logic/ssp_tx_fifo_ctrl.sv
// transmit fifo, control register and transmit shifter of the framed serial port
`timescale 1ns/10ps
`include "ssp_regs.svh"

module ssp_tx_fifo_ctrl #(
    parameter int DEPTH = 16, // transmit fifo depth
    parameter int WIDTH = 16  // transmit word width
) (
    input wire logic mclk_i,               // system clock
    input wire logic resetn_i,             // synchronous reset, low
    input wire ssp_pkg::ssp_req_t req_i,   // register access
    output logic [15:0] rdata_o,           // read data
    input wire logic rx_above_wm_i,        // receive path flag
    input wire logic ctl_rx_full_i,        // receive control-word flag
    input wire logic tx_bit_clock_i,       // transmit bit clock pin
    input wire logic tx_sync_i,            // sync pin input
    output logic tx_sync_o,                // sync pin output
    output logic tx_sync_oe_o,             // sync pin drive enable
    output logic tx_serial_o,              // transmit data pin
    output logic tx_serial_oe_o,           // transmit data drive enable
    output logic tx_irq_o,                 // transmit below watermark to cpu
    output logic tx_dma_req_o,             // transmit below watermark to dma
    output logic rx_irq_o,                 // receive-full to cpu
    output logic rx_dma_req_o,             // receive-full to dma
    output logic ctl_tx_irq_o,             // control-word empty to cpu
    output logic ctl_rx_irq_o,             // control-word full to cpu
    output logic rx_enable_o               // reception enable
);
    import ssp_pkg::*;

    //----------------------------------------------------------------
    // state
    //----------------------------------------------------------------
    ssp_ctrl_t ctrl;
    logic [3:0] tx_watermark;
    logic lsb_first;
    logic tx_buffer_flush;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [3:0] wr_ptr;
    logic [3:0] rd_ptr;
    logic [4:0] tx_fill_count;
    logic tx_below_watermark_flag;
    logic tx_underrun_flag;
    ssp_state_t state;
    logic [15:0] tx_shift_reg;
    logic [3:0] bits_left;
    logic tck_s1;
    logic tck_s2;
    logic tck_s3;
    logic sync_s1;
    logic sync_s2;

    // first bit to drive for a given shift value
    function automatic logic first_bit(input logic [15:0] v, input logic wide,
                                       input logic lsb);
        logic b;
        b = lsb ? v[0] : (wide ? v[15] : v[7]);
        return b;
    endfunction : first_bit

    //----------------------------------------------------------------
    // register decode
    //----------------------------------------------------------------
    wire logic wr_data = req_i.wr && (req_i.addr == `SSP_OFS_TXDATA);
    wire logic wr_ctrl = req_i.wr && (req_i.addr == `SSP_OFS_CTRL);
    wire logic wr_stat = req_i.wr && (req_i.addr == `SSP_OFS_STATUS);
    wire logic wr_fctl = req_i.wr && (req_i.addr == `SSP_OFS_FIFOCTL);
    wire logic wide_word = ctrl.word_length_bit;
    wire logic tx_on = ctrl.tx_enable_bit;
    wire logic int_sync = ctrl.sync_source_sel;
    wire logic interval_mode = ctrl.framing_mode_bit;

    // eight bit mode keeps the low byte only
    wire logic [15:0] wr_word = wide_word ? req_i.wdata : {8'h00, req_i.wdata[7:0]};
    wire logic [15:0] head = mem[rd_ptr];
    wire logic [15:0] head_word = wide_word ? head : {8'h00, head[7:0]};

    //----------------------------------------------------------------
    // transmit engine decisions
    //----------------------------------------------------------------
    wire logic tck_rise = tck_s2 && !tck_s3;
    wire logic has_data = (tx_fill_count != 5'h00);
    wire logic start_int = tx_on && int_sync && has_data;
    wire logic start_ext = tx_on && !int_sync && sync_s2;
    wire logic idle_start = (state == SSP_IDLE) && (start_int || start_ext);
    // continuous mode carries on without a new sync
    wire logic cont_next = (state == SSP_SHIFT) && (bits_left == 4'h0)
                           && !interval_mode && has_data;
    wire logic load_new = tck_rise && tx_on && has_data && (idle_start || cont_next);
    wire logic shift_on = tck_rise && tx_on && (state == SSP_SHIFT)
                          && (bits_left != 4'h0);
    wire logic underrun = tck_rise && (state == SSP_IDLE) && start_ext && !has_data;
    wire logic word_done = tck_rise && (state == SSP_SHIFT) && (bits_left == 4'h0);

    //----------------------------------------------------------------
    // fifo bookkeeping
    //----------------------------------------------------------------
    wire logic push = wr_data && (tx_fill_count != `SSP_FIFO_FULL) && !tx_buffer_flush;
    wire logic pop = load_new && !tx_buffer_flush;
    wire logic [4:0] next_count = 5'(tx_fill_count + {4'h0, push} - {4'h0, pop});
    wire logic [4:0] wm_ext = {1'b0, tx_watermark};
    wire logic flag_set = pop && (next_count <= wm_ext);
    wire logic flag_dma_clr = push && req_i.dma && (next_count > wm_ext);
    wire logic flag_sw_clr = wr_stat && !req_i.wdata[`SSP_ST_BELOW_WM]
                             && (tx_fill_count > wm_ext);
    wire logic underrun_clr = wr_stat && !req_i.wdata[`SSP_ST_UNDERRUN];

    //----------------------------------------------------------------
    // next values of shifter and pins
    //----------------------------------------------------------------
    wire logic [15:0] shifted = lsb_first ? (tx_shift_reg >> 1) : (tx_shift_reg << 1);
    wire logic [15:0] next_shift = load_new ? head_word
                                   : (shift_on ? shifted : tx_shift_reg);
    wire logic [3:0] next_bits = load_new ? (wide_word ? `SSP_BITS16 : `SSP_BITS8)
                                 : (shift_on ? 4'(bits_left - 4'h1) : bits_left);
    wire logic next_serial = (load_new || shift_on)
                             ? first_bit(next_shift, wide_word, lsb_first) : tx_serial_o;
    // internal sync marks the first bit of a framed word
    wire logic next_sync = tck_rise ? (load_new && (state == SSP_IDLE) && int_sync)
                           : tx_sync_o;

    //----------------------------------------------------------------
    // read mux
    //----------------------------------------------------------------
    wire logic [15:0] status_word = (16'h0001 << `SSP_ST_CTL_TX)
        | ({15'h0000, ctl_rx_full_i} << `SSP_ST_CTL_RX)
        | ({15'h0000, tx_underrun_flag} << `SSP_ST_UNDERRUN)
        | ({15'h0000, tx_below_watermark_flag} << `SSP_ST_BELOW_WM);
    wire logic [15:0] fctl_word = ({12'h000, tx_watermark} << `SSP_FC_WM_LO)
        | ({15'h0000, lsb_first} << `SSP_FC_LSB)
        | ({15'h0000, tx_buffer_flush} << `SSP_FC_FLUSH);
    wire logic [15:0] count_word = {11'h000, tx_fill_count} << `SSP_CNT_LO;
    wire logic [15:0] next_rdata =
        (req_i.addr == `SSP_OFS_TXDATA) ? head_word :
        (req_i.addr == `SSP_OFS_CTRL) ? 16'(ctrl) :
        (req_i.addr == `SSP_OFS_STATUS) ? status_word :
        (req_i.addr == `SSP_OFS_FIFOCTL) ? fctl_word :
        (req_i.addr == `SSP_OFS_COUNT) ? count_word : 16'h0000;

    //----------------------------------------------------------------
    // pin synchronisers
    //----------------------------------------------------------------
    // two stages before use, third stage for the edge
    always_ff @(posedge mclk_i) begin
        tck_s1 <= tx_bit_clock_i;
        tck_s2 <= tck_s1;
        tck_s3 <= tck_s2;
        sync_s1 <= tx_sync_i;
        sync_s2 <= sync_s1;
    end

    //----------------------------------------------------------------
    // control and fifo control registers
    //----------------------------------------------------------------
    // reserved bits masked to zero
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            ctrl <= ssp_ctrl_t'(`SSP_CTRL_RESET);
            tx_watermark <= 4'h0;
            lsb_first <= 1'b0;
            tx_buffer_flush <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl <= ssp_ctrl_t'(req_i.wdata & `SSP_CTRL_WMASK);
            end
            if (wr_fctl) begin
                tx_watermark <= req_i.wdata[`SSP_FC_WM_HI:`SSP_FC_WM_LO];
                lsb_first <= req_i.wdata[`SSP_FC_LSB];
                tx_buffer_flush <= req_i.wdata[`SSP_FC_FLUSH];
            end
        end
    end

    //----------------------------------------------------------------
    // fifo storage and pointers
    //----------------------------------------------------------------
    // storage needs no reset
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wr_ptr] <= wr_word;
        end
    end

    // flush or reset empties the fifo
    always_ff @(posedge mclk_i) begin
        if (!resetn_i || tx_buffer_flush) begin
            wr_ptr <= 4'h0;
            rd_ptr <= 4'h0;
            tx_fill_count <= 5'h00;
        end else begin
            wr_ptr <= push ? 4'(wr_ptr + 4'h1) : wr_ptr;
            rd_ptr <= pop ? 4'(rd_ptr + 4'h1) : rd_ptr;
            tx_fill_count <= next_count;
        end
    end

    //----------------------------------------------------------------
    // status flags, set beats clear
    //----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!resetn_i || tx_buffer_flush) begin
            tx_below_watermark_flag <= 1'b1;
            tx_underrun_flag <= 1'b0;
        end else begin
            if (flag_set) begin
                tx_below_watermark_flag <= 1'b1;
            end else if (flag_dma_clr || flag_sw_clr) begin
                tx_below_watermark_flag <= 1'b0;
            end
            if (underrun) begin
                tx_underrun_flag <= 1'b1;
            end else if (underrun_clr) begin
                tx_underrun_flag <= 1'b0;
            end
        end
    end

    //----------------------------------------------------------------
    // transmit engine
    //----------------------------------------------------------------
    // moves on rising bit clock edges; reset or transmit disable forces idle
    always_ff @(posedge mclk_i) begin
        if (!resetn_i || !tx_on) begin
            state <= SSP_IDLE;
            tx_shift_reg <= 16'h0000;
            bits_left <= 4'h0;
        end else begin
            unique case (state)
                SSP_IDLE: begin
                    state <= load_new ? SSP_SHIFT : SSP_IDLE;
                end
                SSP_SHIFT: begin
                    // interval mode goes back for a new sync
                    state <= (word_done && !load_new) ? SSP_IDLE : SSP_SHIFT;
                end
            endcase
            tx_shift_reg <= next_shift;
            bits_left <= next_bits;
        end
    end

    //----------------------------------------------------------------
    // registered outputs
    //----------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            rdata_o <= 16'h0000;
            tx_serial_o <= 1'b0;
            tx_serial_oe_o <= 1'b0;
            tx_sync_o <= 1'b0;
            tx_sync_oe_o <= 1'b0;
        end else begin
            rdata_o <= req_i.rd ? next_rdata : rdata_o;
            tx_serial_o <= next_serial;
            tx_serial_oe_o <= tx_on;
            tx_sync_o <= tx_on && next_sync;
            tx_sync_oe_o <= tx_on && int_sync;
        end
    end

    // requests: bit ten splits data requests, control words go to cpu
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            tx_irq_o <= 1'b0;
            tx_dma_req_o <= 1'b0;
            rx_irq_o <= 1'b0;
            rx_dma_req_o <= 1'b0;
            ctl_tx_irq_o <= 1'b0;
            ctl_rx_irq_o <= 1'b0;
            rx_enable_o <= 1'b0;
        end else begin
            tx_irq_o <= tx_below_watermark_flag && ctrl.tx_irq_en
                        && !ctrl.dma_route_en;
            tx_dma_req_o <= tx_below_watermark_flag && ctrl.tx_irq_en
                            && ctrl.dma_route_en;
            rx_irq_o <= rx_above_wm_i && ctrl.rx_irq_en
                        && !ctrl.dma_route_en;
            rx_dma_req_o <= rx_above_wm_i && ctrl.rx_irq_en
                            && ctrl.dma_route_en;
            ctl_tx_irq_o <= ctrl.ctl_tx_irq_en;
            ctl_rx_irq_o <= ctrl.ctl_rx_irq_en && ctl_rx_full_i;
            rx_enable_o <= ctrl.rx_enable_bit;
        end
    end

endmodule : ssp_tx_fifo_ctrl

// file: dv/ssp_tx_fifo_ctrl_asserts.sv
// concurrent checks on the serial port fifo and control block
`timescale 1ns/10ps
`include "ssp_regs.svh"

module ssp_tx_fifo_ctrl_asserts
    import ssp_pkg::*;
(
    input wire logic mclk_i, // system clock
    input wire logic resetn_i, // synchronous reset, low
    input wire ssp_pkg::ssp_req_t req_i, // register access
    input wire logic [15:0] rdata_o, // read data
    input wire logic rx_above_wm_i, // receive flag
    input wire logic ctl_rx_full_i, // control-word full flag
    input wire logic tx_sync_oe_o, // sync drive enable
    input wire logic tx_serial_oe_o, // data drive enable
    input wire logic tx_irq_o, // transmit request to cpu
    input wire logic tx_dma_req_o, // transmit request to dma
    input wire logic rx_irq_o, // receive request to cpu
    input wire logic rx_dma_req_o, // receive request to dma
    input wire logic ctl_tx_irq_o, // control-word empty irq
    input wire logic ctl_rx_irq_o, // control-word full irq
    input wire logic rx_enable_o // reception enable
);
    ssp_ctrl_t sh;
    ssp_ctrl_t sh_d1;
    ssp_ctrl_t sh_d2;
    wire ctl_wr = req_i.wr && (req_i.addr == `SSP_OFS_CTRL);
    wire settled = (sh == sh_d1) && (sh_d1 == sh_d2);

    // shadow of the control register from observed writes
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            sh <= '0;
        end else if (ctl_wr) begin
            sh <= ssp_ctrl_t'(req_i.wdata & `SSP_CTRL_WMASK);
        end
    end

    // two-cycle history so registered outputs have caught up
    always_ff @(posedge mclk_i) begin
        sh_d1 <= sh;
        sh_d2 <= sh_d1;
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    reset_quiet_a: assert property (disable iff (1'b0)
        !resetn_i |=> !tx_irq_o && !tx_dma_req_o && !rx_irq_o && !rx_dma_req_o
        && !tx_serial_oe_o && !tx_sync_oe_o && !rx_enable_o) else $error("output busy after reset");
    rx_enable_a: assert property (
        settled |-> rx_enable_o == sh.rx_enable_bit) else $error("rx enable wrong");
    tx_pin_drive_a: assert property (settled |-> tx_serial_oe_o == sh.tx_enable_bit
        && tx_sync_oe_o == (sh.tx_enable_bit && sh.sync_source_sel)) else $error("pin drive wrong");
    rx_req_route_a: assert property (settled && $past(resetn_i) |->
        rx_irq_o == ($past(rx_above_wm_i) && sh.rx_irq_en && !sh.dma_route_en)
        && rx_dma_req_o == ($past(rx_above_wm_i) && sh.rx_irq_en && sh.dma_route_en))
        else $error("rx request routing wrong");
    tx_req_route_a: assert property (settled |-> !(tx_irq_o && tx_dma_req_o)
        && (!tx_irq_o || (sh.tx_irq_en && !sh.dma_route_en))
        && (!tx_dma_req_o || (sh.tx_irq_en && sh.dma_route_en))) else $error("tx request wrong");
    ctl_word_irq_a: assert property (settled && $past(resetn_i) |->
        ctl_tx_irq_o == sh.ctl_tx_irq_en && ctl_rx_irq_o == ($past(ctl_rx_full_i)
        && sh.ctl_rx_irq_en)) else $error("control-word irq wrong");
    ctrl_readback_a: assert property (
        req_i.rd && req_i.addr == `SSP_OFS_CTRL && !ctl_wr |-> ##2 rdata_o == $past(sh, 2))
        else $error("control readback wrong");
    rdata_hold_a: assert property (
        !req_i.rd && !$past(req_i.rd) && $past(resetn_i) |=> $stable(rdata_o))
        else $error("read data moved without read");

    cover property (req_i.wr && req_i.dma);
    cover property ($rose(tx_dma_req_o));
    cover property ($rose(rx_irq_o));
endmodule : ssp_tx_fifo_ctrl_asserts

bind ssp_tx_fifo_ctrl ssp_tx_fifo_ctrl_asserts ssp_tx_fifo_ctrl_asserts_i (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(req_i), .rdata_o(rdata_o),
    .rx_above_wm_i(rx_above_wm_i), .ctl_rx_full_i(ctl_rx_full_i), .tx_sync_oe_o(tx_sync_oe_o),
    .tx_serial_oe_o(tx_serial_oe_o), .tx_irq_o(tx_irq_o), .tx_dma_req_o(tx_dma_req_o),
    .rx_irq_o(rx_irq_o), .rx_dma_req_o(rx_dma_req_o), .ctl_tx_irq_o(ctl_tx_irq_o),
    .ctl_rx_irq_o(ctl_rx_irq_o), .rx_enable_o(rx_enable_o));

// file: dv/ssp_codec_model.sv
// behavioural serial codec: bit clock, external sync, word capture
`timescale 1ns/10ps

module ssp_codec_model (
    input wire logic run_i, // bit clock runs while high
    input wire logic ext_sync_i, // request one external sync
    input wire logic wide_i, // sixteen bit words
    input wire logic interval_i, // sync frames every word
    input wire logic serial_i, // data pin value
    input wire logic serial_oe_i, // data pin driven
    input wire logic sync_i, // sync pin value from port
    input wire logic sync_oe_i, // sync pin driven by port
    output logic bclk_o, // bit clock
    output logic sync_o, // external sync drive
    output int nw_o // words captured
);
    logic [15:0] words [0:31];
    logic [15:0] sh;
    logic last;
    logic b;
    logic active;
    int nb;
    wire line = serial_oe_i ? serial_i : ~last; // released line shows no stale bit
    wire fs = sync_oe_i ? sync_i : sync_o;

    // bit clock stands low while run_i is low
    initial begin
        bclk_o = 1'b0;
        sync_o = 1'b0;
        nw_o = 0;
        nb = 0;
        active = 1'b0;
        last = 1'b0;
        sh = '0;
        #7;
        forever begin
            #160;
            bclk_o = run_i ? ~bclk_o : 1'b0;
        end
    end

    // one pulse per request, the bench holds it one period
    always @(negedge bclk_o) sync_o <= ext_sync_i;

    // sample the line at the rising edge, before the port moves it
    always @(posedge bclk_o) begin
        b = line;
        last = b;
        if (fs && !sync_oe_i) begin
            active = 1'b1;
            nb = 0;
        end else if (fs || active) begin
            sh = {sh[14:0], b};
            nb = fs ? 1 : nb + 1;
            active = 1'b1;
            if (nb == (wide_i ? 16 : 8)) begin
                if (nw_o < 32) words[nw_o] = sh;
                nw_o++;
                nb = 0;
                active = !interval_i;
            end
        end
    end
endmodule : ssp_codec_model

// file: dv/tb_ssp_tx_fifo_ctrl.sv
// self-checking bench for the serial port fifo and control block
`timescale 1ns/10ps
`include "ssp_regs.svh"

module tb_ssp_tx_fifo_ctrl;
    import ssp_pkg::*;

    typedef struct packed {
        logic [15:0] wd;
        logic [15:0] rexp;
        logic [1:0] rx;
    } ssp_row_t;

    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    ssp_req_t req_i = '0;
    logic rx_above_wm_i = 1'b0;
    logic ctl_rx_full_i = 1'b0;
    logic run = 1'b0;
    logic ext_sync = 1'b0;
    logic wide = 1'b0;
    logic interval = 1'b0;
    logic [15:0] rdata_o;
    logic tx_sync_o, tx_sync_oe_o, tx_serial_o, tx_serial_oe_o, tx_irq_o, tx_dma_req_o;
    logic rx_irq_o, rx_dma_req_o, ctl_tx_irq_o, ctl_rx_irq_o, rx_enable_o, bclk, cod_sync;
    int nw;
    int failures = 0;
    int compares = 0;
    wire sync_line = tx_sync_oe_o ? tx_sync_o : cod_sync; // two-way sync pin
    ssp_row_t rows [4] = '{'{16'hffff, 16'h077f, 2'b01}, '{16'h0305, 16'h0305, 2'b10},
        '{16'h0aaa, 16'h022a, 2'b00}, '{16'h0000, 16'h0000, 2'b00}};

    always #20 mclk_i = ~mclk_i;

    ssp_tx_fifo_ctrl ssp_tx_fifo_ctrl_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(req_i),
        .rdata_o(rdata_o), .rx_above_wm_i(rx_above_wm_i), .ctl_rx_full_i(ctl_rx_full_i),
        .tx_bit_clock_i(bclk), .tx_sync_i(sync_line), .tx_sync_o(tx_sync_o),
        .tx_sync_oe_o(tx_sync_oe_o), .tx_serial_o(tx_serial_o), .tx_serial_oe_o(tx_serial_oe_o),
        .tx_irq_o(tx_irq_o), .tx_dma_req_o(tx_dma_req_o), .rx_irq_o(rx_irq_o),
        .rx_dma_req_o(rx_dma_req_o), .ctl_tx_irq_o(ctl_tx_irq_o), .ctl_rx_irq_o(ctl_rx_irq_o),
        .rx_enable_o(rx_enable_o));

    ssp_codec_model ssp_codec_model_i (.run_i(run), .ext_sync_i(ext_sync), .wide_i(wide),
        .interval_i(interval), .serial_i(tx_serial_o), .serial_oe_i(tx_serial_oe_o),
        .sync_i(tx_sync_o), .sync_oe_i(tx_sync_oe_o), .bclk_o(bclk), .sync_o(cod_sync),
        .nw_o(nw));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic dm);
        @(negedge mclk_i);
        req_i = '{wr: 1'b1, rd: 1'b0, dma: dm, addr: a, wdata: d};
        @(negedge mclk_i);
        req_i = '0;
    endtask : wr

    task automatic rchk(input string what, input logic [3:0] a, input logic [15:0] exp);
        @(negedge mclk_i);
        req_i = '{wr: 1'b0, rd: 1'b1, dma: 1'b0, addr: a, wdata: 16'h0000};
        @(negedge mclk_i);
        req_i = '0;
        @(negedge mclk_i);
        check(what, exp, rdata_o);
    endtask : rchk

    task automatic do_reset();
        resetn_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        resetn_i = 1'b1;
        rchk("ctrl after reset", `SSP_OFS_CTRL, 16'h0000);
        rchk("status after reset", `SSP_OFS_STATUS, 16'h0202);
        rchk("count after reset", `SSP_OFS_COUNT, 16'h0000);
        $display("test reset done");
    endtask : do_reset

    task automatic wait_words(input int n);
        for (int i = 0; i < 5000 && nw < n; i++) @(negedge mclk_i);
        if (nw < n) begin
            failures++;
            $display("[FAIL] words expected %0d seen %0d", n, nw);
            results();
        end
    endtask : wait_words

    task automatic results();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    // main sequence: table of control values, then link scenarios
    initial begin
        do_reset();
        rchk("unmapped read", 4'he, 16'h0000);
        rx_above_wm_i = 1'b1;
        ctl_rx_full_i = 1'b1;
        foreach (rows[k]) begin
            wr(`SSP_OFS_CTRL, 16'h0000, 1'b0);
            wr(`SSP_OFS_CTRL, rows[k].wd, 1'b0);
            rchk("ctrl readback", `SSP_OFS_CTRL, rows[k].rexp);
            check("rx requests", {14'h0, rows[k].rx}, {14'h0, rx_irq_o, rx_dma_req_o});
        end
        rx_above_wm_i = 1'b0;
        ctl_rx_full_i = 1'b0;
        $display("test control table done");
        interval = 1'b1;
        wr(`SSP_OFS_CTRL, 16'h0468, 1'b0);
        wr(`SSP_OFS_CTRL, 16'h046a, 1'b0);
        @(negedge mclk_i);
        check("dma request at start", 16'h0001, {15'h0, tx_dma_req_o});
        wr(`SSP_OFS_FIFOCTL, 16'h1000, 1'b0);
        wr(`SSP_OFS_TXDATA, 16'ha5c3, 1'b1);
        wr(`SSP_OFS_TXDATA, 16'h015a, 1'b1);
        @(negedge mclk_i);
        check("dma request after fill", 16'h0000, {15'h0, tx_dma_req_o});
        rchk("count two words", `SSP_OFS_COUNT, 16'h0200);
        run = 1'b1;
        wait_words(2);
        repeat (12) @(posedge bclk);
        check("words in interval mode", 16'h0002, nw[15:0]);
        check("first word", 16'h00c3, {8'h0, ssp_codec_model_i.words[0][7:0]});
        check("second word", 16'h005a, {8'h0, ssp_codec_model_i.words[1][7:0]});
        check("dma request after drain", 16'h0001, {15'h0, tx_dma_req_o});
        rchk("status after drain", `SSP_OFS_STATUS, 16'h0202);
        run = 1'b0;
        $display("test interval internal done");
        wr(`SSP_OFS_CTRL, 16'h0000, 1'b0);
        wide = 1'b1;
        interval = 1'b0;
        wr(`SSP_OFS_CTRL, 16'h0012, 1'b0);
        for (int i = 0; i < 16; i++) wr(`SSP_OFS_TXDATA, 16'h1000 + 16'(i), 1'b0);
        rchk("count when full", `SSP_OFS_COUNT, 16'h1000);
        run = 1'b1;
        ext_sync = 1'b1;
        @(negedge bclk);
        @(posedge bclk);
        ext_sync = 1'b0;
        wait_words(18);
        run = 1'b0;
        for (int k = 0; k < 16; k++) begin
            check("word", 16'h1000 + 16'(k), ssp_codec_model_i.words[2 + k]);
        end
        rchk("status no underrun", `SSP_OFS_STATUS, 16'h0202);
        $display("test continuous external done");
        wr(`SSP_OFS_TXDATA, 16'h0c0d, 1'b0);
        wr(`SSP_OFS_FIFOCTL, 16'h0001, 1'b0);
        rchk("count while flush", `SSP_OFS_COUNT, 16'h0000);
        wr(`SSP_OFS_FIFOCTL, 16'h0000, 1'b0);
        wr(`SSP_OFS_TXDATA, 16'h0c0d, 1'b0);
        $display("test flush done");
        do_reset();
        results();
    end
endmodule : tb_ssp_tx_fifo_ctrl
